// ===== subaddr_pkg.sv
// Shared constants and state type for the subaddress correlation packer
package subaddr_pkg;
  localparam logic [3:0] SEP_NIB = 4'hF;
  localparam logic [3:0] FILL_NIB = 4'h0;
  localparam logic [7:0] ABSENT_BYTE = 8'hFF;
  localparam logic [3:0] MAX_DIGIT = 4'h9;
  localparam logic [2:0] TYPE_USER = 3'h2;
  localparam logic EXT_BIT = 1'b1;
  localparam logic [2:0] TYPE_LOW_BITS = 3'h0;
  localparam logic [1:0] DIR_MONO = 2'h0;
  localparam logic [1:0] DIR_FROM_TARGET = 2'h1;
  localparam logic [1:0] DIR_TO_TARGET = 2'h2;
  localparam int DIGIT_FIRST_BYTE = 4;
  localparam int SVC_FIRST_BYTE = 19;
  localparam int SVC_LAST_BYTE = 23;
  localparam int SVC_FIXED = 3;
  localparam int SVC_MAX = SVC_LAST_BYTE - SVC_FIRST_BYTE + 1;
  localparam logic [7:0] CALLING_PAD_NIBS = 8'(2 * (SVC_FIRST_BYTE - DIGIT_FIRST_BYTE));
  localparam logic [7:0] CALLING_BASE_LEN = 8'(SVC_FIRST_BYTE - 3 + SVC_FIXED);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_ID = 3'h1,
    ST_LEN = 3'h3,
    ST_TYPE = 3'h2,
    ST_DIG = 3'h6,
    ST_SEP = 3'h7,
    ST_PAD = 3'h5,
    ST_RAW = 3'h4
  } pack_state_e;
endpackage : subaddr_pkg

// ===== pack_if.sv
// Carrier between the sequencer and the nibble pair packer
`timescale 1ns/1ns
interface pack_if;
  logic nib_vld;
  logic [3:0] nib;
  logic raw_vld;
  logic [7:0] raw;
  logic last;
  logic rdy;
  logic out_vld;
  logic [7:0] out_byte;
  logic out_last;
  logic out_rdy;
  modport src (output nib_vld, nib, raw_vld, raw, last, out_rdy,
               input rdy, out_vld, out_byte, out_last);
  modport pk (input nib_vld, nib, raw_vld, raw, last, out_rdy,
              output rdy, out_vld, out_byte, out_last);
endinterface : pack_if

// ===== nibble_pair_packer.sv
// Joins 4-bit items two to an octet and holds the output byte
`timescale 1ns/1ns
module nibble_pair_packer
(
  input wire logic core_clk,
  input wire logic nrst,
  pack_if.pk p
);
  logic half_ff;
  logic [3:0] low_ff;
  logic vld_ff;
  logic [7:0] byte_ff;
  logic last_ff;
  logic take;

  assign p.rdy = !vld_ff || p.out_rdy;
  assign take = p.rdy && (p.nib_vld || p.raw_vld);
  assign p.out_vld = vld_ff;
  assign p.out_byte = byte_ff;
  assign p.out_last = last_ff;

  // ----------------------------------------
  // Nibble holding
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      half_ff <= 1'b0;
      low_ff <= 4'h0;
    end
    else if (take && p.nib_vld)
    begin
      half_ff <= !half_ff;
      if (!half_ff)
        low_ff <= p.nib;
    end
  end

  // ----------------------------------------
  // Output byte
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vld_ff <= 1'b0;
      byte_ff <= 8'h00;
      last_ff <= 1'b0;
    end
    else if (take && p.raw_vld)
    begin
      vld_ff <= 1'b1;
      byte_ff <= p.raw;
      last_ff <= p.last;
    end
    else if (take && p.nib_vld && half_ff)
    begin
      vld_ff <= 1'b1;
      byte_ff <= {p.nib, low_ff};
      last_ff <= p.last;
    end
    else if (p.out_rdy)
    begin
      vld_ff <= 1'b0;
      last_ff <= 1'b0;
    end
  end
endmodule : nibble_pair_packer

// ===== subaddress_correlation_packer.sv
// Builds called and calling party subaddress octet strings
`timescale 1ns/1ns
// Operation
// - Digits 0..9 go out as their plain 4-bit binary value.
// - Code 1111 marks a field boundary.
// - Earlier item fills low nibble, later item the high nibble.
// - Called: operator code, communication number, content link, national bytes.
// - Calling: interception identifier, direction, service octets.
// - Every field is sent even if empty, separated by separators.
// - An empty first field shows as one separator, a later one as two back to back.
// - A separator also follows the last digit field.
// - Service octets sit at bytes 19 to 23 of the calling string.
// - Missing medium, bearer or high layer octet is sent as FF.
// - No teleservice code: byte 23 is not sent.
// - No teleservice nor bearer service code: bytes 22, 23 not sent.
// - Digit fields accept only decimal codes; others are refused.
// - Direction: 0 mono, 1 from target, 2 to target.
// - Type user specified; odd/even used for called without national bytes.
module subaddress_correlation_packer
#(
  parameter int OP_DIGITS = 3,
  parameter int COMM_DIGITS = 8,
  parameter int CCL_DIGITS = 8,
  parameter int LI_DIGITS = 25,
  parameter int NAT_BYTES = 7,
  parameter logic [7:0] CALLED_IE_ID = 8'h71,
  parameter logic [7:0] CALLING_IE_ID = 8'h6D
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic sel_calling,
  input wire logic [4*OP_DIGITS-1:0] op_digits,
  input wire logic [7:0] op_len,
  input wire logic [4*COMM_DIGITS-1:0] communication_number,
  input wire logic [7:0] comm_len,
  input wire logic [4*CCL_DIGITS-1:0] ccl_digits,
  input wire logic [7:0] ccl_len,
  input wire logic [8*NAT_BYTES-1:0] nat_bytes,
  input wire logic [7:0] nat_len,
  input wire logic [4*LI_DIGITS-1:0] li_digits,
  input wire logic [7:0] li_len,
  input wire logic [1:0] dir_code,
  input wire logic [7:0] transmission_medium_requirement,
  input wire logic medium_vld,
  input wire logic [7:0] bearer_capability_octet,
  input wire logic capability_vld,
  input wire logic [7:0] high_layer_compat_octet,
  input wire logic compat_vld,
  input wire logic [7:0] bearer_svc,
  input wire logic bearer_vld,
  input wire logic [7:0] tele_svc,
  input wire logic tele_vld,
  output logic busy,
  output logic reject,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic out_last,
  input wire logic out_ready
);
  localparam int MAXF = LI_DIGITS;
  localparam int RAWN = (NAT_BYTES > subaddr_pkg::SVC_MAX) ? NAT_BYTES : subaddr_pkg::SVC_MAX;

  pack_if p ();

  subaddr_pkg::pack_state_e st_ff;
  logic calling_ff;
  logic [4*MAXF-1:0] fld_ff [3];
  logic [7:0] flen_ff [3];
  logic [1:0] nfld_ff;
  logic [8*RAWN-1:0] raw_ff;
  logic [7:0] raw_tot_ff;
  logic [7:0] len_byte_ff;
  logic odd_ff;
  logic [7:0] pad_tgt_ff;
  logic [1:0] fi_ff;
  logic [7:0] di_ff;
  logic [7:0] nib_cnt_ff;
  logic [7:0] raw_cnt_ff;
  logic reject_ff;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic has_bad(input logic [4*MAXF-1:0] v, input logic [7:0] n);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < MAXF; i++)
      if ((8'(i) < n) && (v[4*i +: 4] > subaddr_pkg::MAX_DIGIT))
        bad = 1'b1;
    return bad;
  endfunction : has_bad

  function automatic logic [7:0] half_up(input logic [7:0] n);
    return 8'((9'(n) + 9'h001) >> 1);
  endfunction : half_up

  // ----------------------------------------
  // Start decode
  // ----------------------------------------
  logic [7:0] nib_total;
  logic [7:0] svc_extra;
  logic start_bad;
  logic go;

  assign nib_total = 8'(op_len + comm_len + ccl_len + 8'h03);
  // Bearer slot is still sent as FF when only the teleservice code exists
  assign svc_extra = tele_vld ? 8'h02 : (bearer_vld ? 8'h01 : 8'h00);

  always_comb
  begin
    if (sel_calling)
      start_bad = (li_len > 8'(LI_DIGITS)) || has_bad((4*MAXF)'(li_digits), li_len)
                  || (dir_code > subaddr_pkg::DIR_TO_TARGET);
    else
      start_bad = (op_len > 8'(OP_DIGITS)) || (comm_len > 8'(COMM_DIGITS))
                  || (ccl_len > 8'(CCL_DIGITS)) || (nat_len > 8'(NAT_BYTES))
                  || has_bad((4*MAXF)'(op_digits), op_len)
                  || has_bad((4*MAXF)'(communication_number), comm_len)
                  || has_bad((4*MAXF)'(ccl_digits), ccl_len);
  end

  assign go = start && (st_ff == subaddr_pkg::ST_IDLE) && !start_bad;

  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      calling_ff <= 1'b0;
      fld_ff <= '{default: '0};
      flen_ff <= '{default: 8'h00};
      nfld_ff <= 2'h0;
      raw_ff <= '0;
      raw_tot_ff <= 8'h00;
      len_byte_ff <= 8'h00;
      odd_ff <= 1'b0;
      pad_tgt_ff <= 8'h00;
    end
    else if (go && sel_calling)
    begin
      calling_ff <= 1'b1;
      fld_ff[0] <= (4*MAXF)'(li_digits);
      fld_ff[1] <= (4*MAXF)'({2'b00, dir_code});
      flen_ff[0] <= li_len;
      flen_ff[1] <= 8'h01;
      nfld_ff <= 2'h2;
      raw_ff <= (8*RAWN)'({tele_svc, bearer_vld ? bearer_svc : subaddr_pkg::ABSENT_BYTE,
                 compat_vld ? high_layer_compat_octet : subaddr_pkg::ABSENT_BYTE,
                 capability_vld ? bearer_capability_octet : subaddr_pkg::ABSENT_BYTE,
                 medium_vld ? transmission_medium_requirement
                 : subaddr_pkg::ABSENT_BYTE});
      raw_tot_ff <= 8'(subaddr_pkg::SVC_FIXED) + svc_extra;
      len_byte_ff <= subaddr_pkg::CALLING_BASE_LEN + svc_extra;
      odd_ff <= 1'b0;
      pad_tgt_ff <= subaddr_pkg::CALLING_PAD_NIBS;
    end
    else if (go)
    begin
      calling_ff <= 1'b0;
      fld_ff[0] <= (4*MAXF)'(op_digits);
      fld_ff[1] <= (4*MAXF)'(communication_number);
      fld_ff[2] <= (4*MAXF)'(ccl_digits);
      flen_ff[0] <= op_len;
      flen_ff[1] <= comm_len;
      flen_ff[2] <= ccl_len;
      nfld_ff <= 2'h3;
      raw_ff <= (8*RAWN)'(nat_bytes);
      raw_tot_ff <= nat_len;
      len_byte_ff <= 8'(8'h01 + half_up(nib_total) + nat_len);
      odd_ff <= (nat_len == 8'h00) && nib_total[0];
      pad_tgt_ff <= 8'(half_up(nib_total) << 1);
    end
  end

  // ----------------------------------------
  // Item sequencing
  // ----------------------------------------
  logic [7:0] nib_next;
  logic more_pad;
  logic last_sep;
  logic end_now;

  assign nib_next = 8'(nib_cnt_ff + 8'h01);
  assign more_pad = nib_next < pad_tgt_ff;
  assign last_sep = (2'(fi_ff + 2'h1) == nfld_ff);
  always_comb
  begin
    end_now = 1'b0;
    if ((st_ff == subaddr_pkg::ST_SEP) || (st_ff == subaddr_pkg::ST_PAD))
      end_now = ((st_ff == subaddr_pkg::ST_PAD) || last_sep) && !more_pad
                && (raw_tot_ff == 8'h00);
    else if (st_ff == subaddr_pkg::ST_RAW)
      end_now = (8'(raw_cnt_ff + 8'h01) == raw_tot_ff);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= subaddr_pkg::ST_IDLE;
      fi_ff <= 2'h0;
      di_ff <= 8'h00;
      nib_cnt_ff <= 8'h00;
      raw_cnt_ff <= 8'h00;
    end
    else if (go)
    begin
      st_ff <= subaddr_pkg::ST_ID;
      fi_ff <= 2'h0;
      di_ff <= 8'h00;
      nib_cnt_ff <= 8'h00;
      raw_cnt_ff <= 8'h00;
    end
    else if (p.rdy)
    begin
      case (st_ff)
        subaddr_pkg::ST_ID: st_ff <= subaddr_pkg::ST_LEN;
        subaddr_pkg::ST_LEN: st_ff <= subaddr_pkg::ST_TYPE;
        subaddr_pkg::ST_TYPE:
          st_ff <= (flen_ff[0] == 8'h00) ? subaddr_pkg::ST_SEP : subaddr_pkg::ST_DIG;
        subaddr_pkg::ST_DIG:
        begin
          nib_cnt_ff <= nib_next;
          di_ff <= 8'(di_ff + 8'h01);
          if (8'(di_ff + 8'h01) == flen_ff[fi_ff])
            st_ff <= subaddr_pkg::ST_SEP;
        end
        subaddr_pkg::ST_SEP, subaddr_pkg::ST_PAD:
        begin
          nib_cnt_ff <= nib_next;
          di_ff <= 8'h00;
          if ((st_ff == subaddr_pkg::ST_SEP) && !last_sep)
          begin
            fi_ff <= 2'(fi_ff + 2'h1);
            st_ff <= (flen_ff[2'(fi_ff + 2'h1)] == 8'h00) ? subaddr_pkg::ST_SEP
                     : subaddr_pkg::ST_DIG;
          end
          else if (more_pad)
            st_ff <= subaddr_pkg::ST_PAD;
          else if (raw_tot_ff != 8'h00)
            st_ff <= subaddr_pkg::ST_RAW;
          else
            st_ff <= subaddr_pkg::ST_IDLE;
        end
        subaddr_pkg::ST_RAW:
        begin
          raw_cnt_ff <= 8'(raw_cnt_ff + 8'h01);
          if (end_now)
            st_ff <= subaddr_pkg::ST_IDLE;
        end
        default: st_ff <= subaddr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reject_ff <= 1'b0;
    else
      reject_ff <= start && ((st_ff != subaddr_pkg::ST_IDLE) || start_bad);
  end

  // ----------------------------------------
  // Item values toward the packer
  // ----------------------------------------
  always_comb
  begin
    p.nib_vld = 1'b0;
    p.nib = subaddr_pkg::SEP_NIB;
    p.raw_vld = 1'b0;
    p.raw = 8'h00;
    case (st_ff)
      subaddr_pkg::ST_ID:
      begin
        p.raw_vld = 1'b1;
        p.raw = calling_ff ? CALLING_IE_ID : CALLED_IE_ID;
      end
      subaddr_pkg::ST_LEN:
      begin
        p.raw_vld = 1'b1;
        p.raw = len_byte_ff;
      end
      subaddr_pkg::ST_TYPE:
      begin
        p.raw_vld = 1'b1;
        p.raw = {subaddr_pkg::EXT_BIT, subaddr_pkg::TYPE_USER, odd_ff,
                 subaddr_pkg::TYPE_LOW_BITS};
      end
      subaddr_pkg::ST_DIG:
      begin
        p.nib_vld = 1'b1;
        p.nib = fld_ff[fi_ff][4*di_ff +: 4];
      end
      subaddr_pkg::ST_SEP:
      begin
        p.nib_vld = 1'b1;
        p.nib = subaddr_pkg::SEP_NIB;
      end
      subaddr_pkg::ST_PAD:
      begin
        // Calling pads with separators up to the fixed service slot
        p.nib_vld = 1'b1;
        p.nib = calling_ff ? subaddr_pkg::SEP_NIB : subaddr_pkg::FILL_NIB;
      end
      subaddr_pkg::ST_RAW:
      begin
        p.raw_vld = 1'b1;
        p.raw = raw_ff[8*raw_cnt_ff +: 8];
      end
      default:
      begin
        p.raw_vld = 1'b0;
      end
    endcase
  end

  assign p.last = end_now;
  assign p.out_rdy = out_ready;

  nibble_pair_packer u_packer
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .p(p)
  );

  assign busy = (st_ff != subaddr_pkg::ST_IDLE) || p.out_vld;
  assign reject = reject_ff;
  assign out_valid = p.out_vld;
  assign out_byte = p.out_byte;
  assign out_last = p.out_last;
endmodule : subaddress_correlation_packer

// ===== subaddress_correlation_packer_assertions.sv
// Port checks for the subaddress packer
`timescale 1ns/1ns
module subaddr_chk
#(
  parameter int OP_DIGITS = 3,
  parameter logic [7:0] CALLED_IE_ID = 8'h71,
  parameter logic [7:0] CALLING_IE_ID = 8'h6D
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic sel_calling,
  input wire logic [4*OP_DIGITS-1:0] op_digits,
  input wire logic [7:0] op_len,
  input wire logic [1:0] dir_code,
  input wire logic busy,
  input wire logic reject,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_last,
  input wire logic out_ready
);
  logic [7:0] idx_ff;
  logic [7:0] len_ff;
  logic calling_ff;
  logic take;
  assign take = out_valid && out_ready;
  // ----
  // Byte position tracking
  // ----
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      idx_ff <= 8'h00;
    else if (take)
      idx_ff <= out_last ? 8'h00 : idx_ff + 8'h01;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      len_ff <= 8'h00;
    else if (take && idx_ff == 8'h01)
      len_ff <= out_byte;
  end
  // Taken only when idx_ff is 0 and no byte is valid, so a start while a byte is out leaves it
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      calling_ff <= 1'b0;
    else if (start && idx_ff == 8'h00 && !out_valid)
      calling_ff <= sel_calling;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  bad_dir_a: assert property (start && sel_calling && dir_code == 2'h3 |=> reject)
    else $error("bad direction not refused");
  bad_digit_a: assert property (start && !sel_calling && op_len != 8'h00 &&
    op_digits[3:0] > 4'h9 |=> reject) else $error("bad digit not refused");
  first_byte_a: assert property (start && !busy ##1 !reject |-> ##[0:2] out_valid)
    else $error("no first byte");
  hold_byte_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_byte) && $stable(out_last)) else $error("byte dropped");
  id_byte_a: assert property (out_valid && idx_ff == 8'h00 |->
    out_byte == (calling_ff ? CALLING_IE_ID : CALLED_IE_ID)) else $error("wrong identifier");
  type_byte_a: assert property (out_valid && idx_ff == 8'h02 |->
    out_byte[7:4] == 4'hA && out_byte[2:0] == 3'h0 && !(calling_ff && out_byte[3]))
    else $error("wrong type byte");
  len_match_a: assert property (take && out_last |-> idx_ff == len_ff + 8'h01)
    else $error("length byte mismatch");
  calling_len_a: assert property (out_valid && idx_ff == 8'h01 && calling_ff |->
    out_byte inside {8'h13, 8'h14, 8'h15}) else $error("calling length out of range");
  last_valid_a: assert property (out_last |-> out_valid)
    else $error("last without valid");
  cover property (take && out_last && calling_ff);
  cover property (take && out_last && !calling_ff);
  cover property (reject);
  cover property (out_valid && !out_ready);
endmodule : subaddr_chk
bind subaddress_correlation_packer subaddr_chk #(.OP_DIGITS(OP_DIGITS),
  .CALLED_IE_ID(CALLED_IE_ID), .CALLING_IE_ID(CALLING_IE_ID)) u_subaddr_chk (.*);

// ===== stack_model.sv
// Signalling stack model that takes the subaddress bytes
`timescale 1ns/1ns
module stack_model
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_last,
  output logic out_ready
);
  logic [1:0] cnt_ff;
  logic [7:0] got[$];
  int n_last;
  int last_pos;
  // Ready one cycle in four while stalling, so held bytes are exercised
  assign out_ready = !stall || (cnt_ff == 2'h0);
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= 2'h0;
    else
      cnt_ff <= cnt_ff + 2'h1;
  end
  always @(posedge core_clk)
  begin
    if (nrst && out_valid && out_ready)
    begin
      got.push_back(out_byte);
      if (out_last)
      begin
        n_last++;
        last_pos = got.size() - 1;
      end
    end
  end
endmodule : stack_model

// ===== subaddress_correlation_packer_tb.sv
// Self-checking bench for the subaddress correlation packer
`timescale 1ns/1ns
module subaddress_correlation_packer_tb;
  logic core_clk, nrst, start, sel_calling, stall;
  logic [11:0] op_digits;
  logic [31:0] communication_number, ccl_digits;
  logic [55:0] nat_bytes;
  logic [99:0] li_digits;
  logic [7:0] op_len, comm_len, ccl_len, nat_len, li_len;
  logic [1:0] dir_code;
  logic [7:0] transmission_medium_requirement, bearer_capability_octet, high_layer_compat_octet;
  logic [7:0] bearer_svc, tele_svc;
  logic medium_vld, capability_vld, compat_vld, bearer_vld, tele_vld;
  logic busy, reject, out_valid, out_last, out_ready;
  logic [7:0] out_byte;
  logic [7:0] exp_q[$];
  logic [3:0] nq[$];
  int err_total;
  int samples_checked;
  int cyc;
  subaddress_correlation_packer u_subaddress_correlation_packer (.*);
  stack_model u_stack_model (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      $display("unexpected %0t timeout", $time);
      wrap_up();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk
  task automatic pack_nibs();
    for (int i = 0; i < nq.size(); i += 2)
      exp_q.push_back({nq[i+1], nq[i]});
    nq.delete();
  endtask : pack_nibs
  task automatic go(input logic twice);
    u_stack_model.got.delete();
    u_stack_model.n_last = 0;
    @(negedge core_clk);
    start = 1'b1;
    if (twice)
      @(negedge core_clk);
    @(negedge core_clk);
    start = 1'b0;
  endtask : go
  task automatic collect(input string nm);
    for (int i = 0; i < 3000 && u_stack_model.n_last == 0; i++)
      @(negedge core_clk);
    chk(u_stack_model.got.size() == exp_q.size(), "byte count");
    foreach (exp_q[i])
      chk(u_stack_model.got[i] === exp_q[i], "byte value");
    chk(u_stack_model.last_pos == exp_q.size() - 1, "last flag");
    chk(busy === 1'b0, "busy after last byte");
    exp_q.delete();
    $display("test %s done", nm);
  endtask : collect
  task automatic t_called_odd();
    stall = 1'b1;
    sel_calling = 1'b0;
    op_len = 8'h03;
    op_digits = 12'h321;
    comm_len = 8'h03;
    communication_number = 32'h0000_0908;
    exp_q = '{8'h71, 8'h06, 8'hA8, 8'h21, 8'hF3, 8'h08, 8'hF9, 8'h0F};
    go(1'b1);
    chk(reject === 1'b1, "second start not refused");
    collect("called_odd");
  endtask : t_called_odd
  task automatic t_called_nat();
    stall = 1'b0;
    op_len = 8'h00;
    comm_len = 8'h01;
    communication_number = 32'h0000_0009;
    ccl_len = 8'h02;
    ccl_digits = 32'h0000_0054;
    nat_len = 8'h02;
    nat_bytes = 56'h0000_0000_00CD_AB;
    exp_q = '{8'h71, 8'h06, 8'hA0, 8'h9F, 8'h4F, 8'hF5, 8'hAB, 8'hCD};
    go(1'b0);
    collect("called_nat");
  endtask : t_called_nat
  task automatic t_calling();
    sel_calling = 1'b1;
    li_digits = 100'h7;
    for (int k = 0; k < 3; k++)
    begin
      stall = k[0];
      dir_code = 2'(k);
      li_len = (k == 0) ? 8'h00 : 8'h01;
      medium_vld = (k != 2);
      capability_vld = (k != 1);
      compat_vld = (k != 0);
      bearer_vld = (k == 1);
      tele_vld = (k == 2);
      exp_q = '{8'h6D, 8'(19 + k), 8'hA0};
      if (k != 0)
        nq.push_back(4'h7);
      nq.push_back(4'hF);
      nq.push_back(4'(k));
      nq.push_back(4'hF);
      // Fill nibbles run up to byte 18
      while (nq.size() < 30)
        nq.push_back(4'hF);
      pack_nibs();
      exp_q.push_back(medium_vld ? 8'h11 : 8'hFF);
      exp_q.push_back(capability_vld ? 8'h22 : 8'hFF);
      exp_q.push_back(compat_vld ? 8'h33 : 8'hFF);
      if (k == 1)
        exp_q.push_back(8'h44);
      if (k == 2)
        exp_q.push_back(8'hFF);
      if (k == 2)
        exp_q.push_back(8'h55);
      go(1'b0);
      collect("calling");
    end
  endtask : t_calling
  task automatic t_refuse();
    dir_code = 2'h3;
    go(1'b0);
    chk(reject === 1'b1, "direction 3 taken");
    dir_code = 2'h0;
    li_len = 8'h08;
    li_digits = 100'hA000_0000;
    go(1'b0);
    chk(reject === 1'b1, "identifier digit A taken");
    sel_calling = 1'b0;
    op_len = 8'h01;
    op_digits = 12'h00A;
    go(1'b0);
    chk(reject === 1'b1, "digit A taken");
    repeat (6) @(negedge core_clk);
    chk(u_stack_model.got.size() == 0 && out_valid === 1'b0, "refused output");
    $display("test refuse done");
  endtask : t_refuse
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial
  begin
    {nrst, start, sel_calling, stall, op_digits, op_len, communication_number, comm_len} = '0;
    {ccl_digits, ccl_len, nat_bytes, nat_len, li_digits, li_len, dir_code} = '0;
    {transmission_medium_requirement, bearer_capability_octet, high_layer_compat_octet,
      bearer_svc, tele_svc} = 40'h11_22_33_44_55;
    {medium_vld, capability_vld, compat_vld, bearer_vld, tele_vld} = 5'h1F;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    t_called_odd();
    t_called_nat();
    t_calling();
    t_refuse();
    wrap_up();
  end
endmodule : subaddress_correlation_packer_tb
